// ### verilog/bip_pkg.sv
// Purpose: constants for the board interrupt priority encoder
// Assumes: one clock, synchronous active-high reset
// Notes: levels are 3-bit, 0 means idle
`default_nettype none
package bip_pkg;
   localparam logic [2:0] LVL_IDLE = 3'h0;
   localparam logic [2:0] LVL_PARITY = 3'h7;
   localparam logic [2:0] LVL_CTPU = 3'h6;
   localparam logic [2:0] LVL_DISK = 3'h4;
   localparam logic [2:0] LVL_SERIAL = 3'h2;
   localparam logic [2:0] LVL_NET = 3'h1;
   // on-card and bus source codes, reported during acknowledge
   localparam logic [3:0] SRC_NONE = 4'h0;
   localparam logic [3:0] SRC_PARITY = 4'h1;
   localparam logic [3:0] SRC_CTPU = 4'h2;
   localparam logic [3:0] SRC_DISK = 4'h3;
   localparam logic [3:0] SRC_SER_A = 4'h4;
   localparam logic [3:0] SRC_SER_B = 4'h5;
   localparam logic [3:0] SRC_NET = 4'h6;
   localparam logic [3:0] SRC_BUS = 4'h7;
   // counter/timer unit cause order, index 0 served first
   localparam int CTPU_CAUSES = 5;
   localparam int SER_CAUSES = 3;
   typedef enum logic [1:0] {BIP_IDLE, BIP_ANSWER} bip_state_e;
endpackage : bip_pkg
`default_nettype wire

// ### verilog/bip_first_set.sv
// Purpose: fixed-priority picker, lowest index wins
// Assumes: req bit 0 is the highest priority
// Notes: one-hot grant plus any flag
`default_nettype none
module bip_first_set #(
   parameter int N = 5
) (
   input wire logic [N-1:0] req_in,
   output logic [N-1:0] grant_out,
   output logic any_out
);
   always_comb begin
      grant_out = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req_in[i]) begin
            grant_out = '0;
            grant_out[i] = 1'b1;
         end
      end
   end
   assign any_out = |req_in;
endmodule : bip_first_set
`default_nettype wire

// ### verilog/bip_encoder.sv
// Purpose: merges bus and on-card interrupt requests into one level for the processor
// Assumes: all inputs synchronous to sys_clk_in
// Notes: the processor masking is outside; this block reports raw level and answers acks
`default_nettype none
module bip_encoder
   import bip_pkg::*;
(
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic [7:1] bus_irq_in,
   input wire logic [7:1] bus_irq_enable_in,
   input wire logic parity_fault_in,
   input wire logic [CTPU_CAUSES-1:0] ctpu_cause_in,
   input wire logic [SER_CAUSES-1:0] ser_a_cause_in,
   input wire logic [SER_CAUSES-1:0] ser_b_cause_in,
   input wire logic disk_irq_in,
   input wire logic net_irq_in,
   input wire logic [2:0] cpu_mask_in,
   input wire logic ack_in,
   input wire logic [2:0] ack_level_in,
   output logic [2:0] ipl_out,
   output logic ack_done_out,
   output logic autovector_out,
   output logic bus_vector_out,
   output logic [3:0] ack_source_out,
   output logic [CTPU_CAUSES-1:0] ctpu_grant_out,
   output logic [SER_CAUSES-1:0] ser_grant_out
);
   logic [7:1] bus_live;
   logic [7:1] card_live;
   logic [2:0] lvl_d;
   logic [2:0] lvl_q;
   logic [CTPU_CAUSES-1:0] ctpu_pick;
   logic [SER_CAUSES-1:0] ser_a_pick;
   logic [SER_CAUSES-1:0] ser_b_pick;
   logic ctpu_any;
   logic ser_a_any;
   logic ser_b_any;
   logic [3:0] src_d;
   logic auto_d;
   logic busv_d;
   logic [SER_CAUSES-1:0] sgrant_d;
   bip_state_e state_q;

   bip_first_set #(.N(CTPU_CAUSES)) u_ctpu (
      .req_in(ctpu_cause_in),
      .grant_out(ctpu_pick),
      .any_out(ctpu_any)
   );
   bip_first_set #(.N(SER_CAUSES)) u_ser_a (
      .req_in(ser_a_cause_in),
      .grant_out(ser_a_pick),
      .any_out(ser_a_any)
   );
   bip_first_set #(.N(SER_CAUSES)) u_ser_b (
      .req_in(ser_b_cause_in),
      .grant_out(ser_b_pick),
      .any_out(ser_b_any)
   );

   assign bus_live = bus_irq_in & bus_irq_enable_in;

   always_comb begin
      card_live = '0;
      card_live[LVL_PARITY] = parity_fault_in;
      card_live[LVL_CTPU] = ctpu_any;
      card_live[LVL_DISK] = disk_irq_in;
      card_live[LVL_SERIAL] = ser_a_any | ser_b_any;
      card_live[LVL_NET] = net_irq_in;
   end

   // highest pending level; masking left to the processor
   always_comb begin
      lvl_d = LVL_IDLE;
      for (int l = 1; l <= 7; l++) begin
         if (bus_live[l] | card_live[l]) begin
            lvl_d = l[2:0];
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         lvl_q <= LVL_IDLE;
      end else begin
         lvl_q <= lvl_d;
      end
   end
   assign ipl_out = lvl_q;

   // acknowledge decode for the level the processor is serving
   always_comb begin
      src_d = SRC_NONE;
      auto_d = 1'b0;
      busv_d = 1'b0;
      sgrant_d = '0;
      if (card_live[ack_level_in]) begin
         case (ack_level_in)
            LVL_PARITY: begin
               src_d = SRC_PARITY;
               auto_d = 1'b1;
            end
            LVL_CTPU: src_d = SRC_CTPU;
            LVL_DISK: begin
               src_d = SRC_DISK;
               auto_d = 1'b1;
            end
            LVL_SERIAL: begin
               if (ser_a_any) begin
                  src_d = SRC_SER_A;
                  sgrant_d = ser_a_pick;
               end else begin
                  src_d = SRC_SER_B;
                  sgrant_d = ser_b_pick;
               end
            end
            LVL_NET: begin
               src_d = SRC_NET;
               auto_d = 1'b1;
            end
            default: src_d = SRC_NONE;
         endcase
      end else if (ack_level_in != LVL_IDLE && bus_live[ack_level_in]) begin
         src_d = SRC_BUS;
         busv_d = 1'b1;
      end
   end

   // one answer pulse per ack; ack must drop before the next is taken
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         state_q <= BIP_IDLE;
      end else begin
         case (state_q)
            BIP_IDLE: if (ack_in) state_q <= BIP_ANSWER;
            BIP_ANSWER: if (!ack_in) state_q <= BIP_IDLE;
            default: state_q <= BIP_IDLE;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         ack_done_out <= 1'b0;
         autovector_out <= 1'b0;
         bus_vector_out <= 1'b0;
         ack_source_out <= SRC_NONE;
         ctpu_grant_out <= '0;
         ser_grant_out <= '0;
      end else begin
         ack_done_out <= ack_in && state_q == BIP_IDLE;
         if (ack_in && state_q == BIP_IDLE) begin
            autovector_out <= auto_d;
            bus_vector_out <= busv_d;
            ack_source_out <= src_d;
            ctpu_grant_out <= (src_d == SRC_CTPU) ? ctpu_pick : '0;
            ser_grant_out <= sgrant_d;
         end
      end
   end

   parity_top_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      parity_fault_in |=> ipl_out == 3'h7)
      else $error("parity fault not at level 7");
   level_seven_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (bus_irq_in[7] & bus_irq_enable_in[7]) |=> ipl_out == 3'h7)
      else $error("level seven request not presented");
   parity_auto_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (ack_in && state_q == BIP_IDLE && ack_level_in == 3'h7 && parity_fault_in)
      |=> autovector_out && ack_done_out && !bus_vector_out)
      else $error("parity ack not autovectored");
   ctpu_vec_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (ack_in && state_q == BIP_IDLE && ack_level_in == 3'h6 && ctpu_cause_in[0])
      |=> !autovector_out && ctpu_grant_out == 5'h01)
      else $error("timer three not first at level 6");
   ser_a_first_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (ack_in && state_q == BIP_IDLE && ack_level_in == 3'h2 && |ser_a_cause_in)
      |=> ack_source_out == SRC_SER_A)
      else $error("serial channel A not served first");
   ser_cause_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (ack_in && state_q == BIP_IDLE && ack_level_in == 3'h2 && ser_a_cause_in[0])
      |=> ser_grant_out == 3'h1)
      else $error("receive ready not ranked first");
   card_wins_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (ack_in && state_q == BIP_IDLE && ack_level_in == 3'h4 && disk_irq_in)
      |=> !bus_vector_out && ack_source_out == SRC_DISK && autovector_out)
      else $error("on-card source not granted ahead of bus");
   bus_gate_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      ((bus_irq_in & bus_irq_enable_in) == 7'h00 && !parity_fault_in && !ctpu_any && !disk_irq_in
       && !ser_a_any && !ser_b_any && !net_irq_in) |=> ipl_out == 3'h0)
      else $error("level shown with nothing pending");
   net_level_a: assert property (@(posedge sys_clk_in) disable iff (rst_in)
      (net_irq_in && bus_irq_in == 7'h00 && !parity_fault_in && !ctpu_any && !disk_irq_in
       && !ser_a_any && !ser_b_any) |=> ipl_out == 3'h1)
      else $error("network not at level 1");
endmodule : bip_encoder
`default_nettype wire

// ### tb/bip_cpu_model.sv
// Purpose: processor side of the encoder, masks and acknowledges
// Assumes: drives on the falling edge, holds ack until answered
// Notes: one acknowledge at a time, dropped for a cycle between
`default_nettype none
module bip_cpu_model (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic [2:0] ipl_in,
   input wire logic [2:0] mask_in,
   input wire logic done_in,
   output logic ack_out,
   output logic [2:0] level_out,
   output var int acks_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic got;
   initial begin
      ack_out = 1'b0;
      level_out = 3'h0;
      acks_out = 0;
      got = 1'b0;
   end
   always @(posedge clk_in) begin
      if (ack_out && done_in) got <= 1'b1;
   end
   always @(negedge clk_in) begin
      if (rst_in || got) begin
         if (got) acks_out <= acks_out + 1;
         ack_out <= 1'b0;
         // released level does not keep its last value
         level_out <= ~level_out;
         got <= 1'b0;
      end else if (!ack_out && ipl_in != 3'h0 && (ipl_in == 3'h7 || ipl_in > mask_in)) begin
         ack_out <= 1'b1;
         level_out <= ipl_in;
      end
   end
endmodule : bip_cpu_model
`default_nettype wire

// ### tb/board_interrupt_priority_encoder_test.sv
// Purpose: self-checking bench for the interrupt priority encoder
// Assumes: processor model acknowledges whatever it does not mask
// Notes: every scenario starts and ends with no source pending
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e); end end
module board_interrupt_priority_encoder_test
   import bip_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk, rst, par, disk, net, ack, done, av, bv;
   logic [7:1] bus_irq, bus_en;
   logic [4:0] ctpu, cg;
   logic [2:0] sa, sb, sg, mask, alvl, ipl;
   logic [3:0] src;
   int n_fail = 0;
   int checks = 0;
   int acks;
   bip_encoder uut (.sys_clk_in(clk), .rst_in(rst), .bus_irq_in(bus_irq), .bus_irq_enable_in(bus_en),
      .parity_fault_in(par), .ctpu_cause_in(ctpu), .ser_a_cause_in(sa), .ser_b_cause_in(sb),
      .disk_irq_in(disk), .net_irq_in(net), .cpu_mask_in(mask), .ack_in(ack), .ack_level_in(alvl),
      .ipl_out(ipl), .ack_done_out(done), .autovector_out(av), .bus_vector_out(bv),
      .ack_source_out(src), .ctpu_grant_out(cg), .ser_grant_out(sg));
   bip_cpu_model cpu (.clk_in(clk), .rst_in(rst), .ipl_in(ipl), .mask_in(mask), .done_in(done),
      .ack_out(ack), .level_out(alvl), .acks_out(acks));
   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask : step
   task automatic idle();
      {bus_irq, par, ctpu, sa, sb, disk, net} = '0;
      step(6);
   endtask : idle
   task automatic serve(input logic [2:0] l, input logic [3:0] s, input logic a, input logic b);
      int i;
      for (i = 0; i < 20 && done !== 1'b1; i++) @(negedge clk);
      `CHK(ipl, l)
      `CHK(src, s)
      `CHK(av, a)
      `CHK(bv, b)
   endtask : serve
   task automatic t_ctpu();
      int i;
      for (i = 0; i < CTPU_CAUSES; i++) begin
         ctpu = 5'h1f << i;
         bus_irq[6] = 1'b1;
         serve(LVL_CTPU, SRC_CTPU, 1'b0, 1'b0);
         `CHK(cg, 5'h01 << i)
         idle();
      end
   endtask : t_ctpu
   task automatic t_ser();
      int i;
      for (i = 0; i < SER_CAUSES; i++) begin
         sa = 3'h7 << i;
         sb = 3'h7;
         serve(LVL_SERIAL, SRC_SER_A, 1'b0, 1'b0);
         `CHK(sg, 3'h1 << i)
         idle();
      end
      sb = 3'h4;
      serve(LVL_SERIAL, SRC_SER_B, 1'b0, 1'b0);
      `CHK(sg, 3'h4)
      idle();
   endtask : t_ser
   task automatic t_misc();
      mask = 3'h7;
      par = 1'b1;
      serve(LVL_PARITY, SRC_PARITY, 1'b1, 1'b0);
      idle();
      mask = 3'h0;
      disk = 1'b1;
      bus_irq[4] = 1'b1;
      serve(LVL_DISK, SRC_DISK, 1'b1, 1'b0);
      disk = 1'b0;
      step(4);
      serve(LVL_DISK, SRC_BUS, 1'b0, 1'b1);
      idle();
      net = 1'b1;
      serve(LVL_NET, SRC_NET, 1'b1, 1'b0);
      idle();
   endtask : t_misc
   task automatic t_mask();
      int n;
      bus_en = 7'h6f;
      bus_irq[5] = 1'b1;
      step(4);
      `CHK(ipl, LVL_IDLE)
      bus_en = 7'h7f;
      serve(3'h5, SRC_BUS, 1'b0, 1'b1);
      idle();
      mask = 3'h5;
      disk = 1'b1;
      n = acks;
      step(10);
      `CHK(acks, n)
      `CHK(ipl, LVL_DISK)
      idle();
   endtask : t_mask
   task automatic print_verdict();
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask : print_verdict
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      rst = 1'b1;
      bus_en = 7'h7f;
      mask = 3'h0;
      {bus_irq, par, ctpu, sa, sb, disk, net} = '0;
      step(8);
      rst = 1'b0;
      step(2);
      `CHK(ipl, LVL_IDLE)
      t_ctpu();
      t_ser();
      t_misc();
      t_mask();
      print_verdict();
   end
   initial begin
      // far beyond the some 140 cycles the scenarios need
      #400000;
      n_fail++;
      print_verdict();
   end
endmodule : board_interrupt_priority_encoder_test
`default_nettype wire
